/* hw/adp_datapath.sv */
// Accumulators, pointer-mapped RAM, condition flags and AXI4-Lite access.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module adp_datapath (
    input wire logic aclk,
    input wire logic aresetn,
    input wire adp_pkg::adp_op_t seq_op,
    output logic seq_ready,
    output adp_pkg::adp_flags_t cond_flags,
    output logic jump_taken,
    input wire logic [7:0] gpio_pins,
    input wire logic [23:0] key_inputs,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import adp_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [RAM_WORDS-1:0][WORD_W-1:0] ram; // RL1
        logic [2:0][WORD_W-1:0] acc;
        logic [7:0] ptr;
        adp_flags_t flags;
        logic jump_taken;
        logic halt;
        logic seq_ready;
        logic [7:0] gpio_s1;
        logic [7:0] gpio_s2;
        logic [7:0] gpio_last;
        logic [23:0] key_s1;
        logic [23:0] key_s2;
        logic [23:0] key_last;
        logic aw_held;
        logic [11:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } adp_dp_state_t;

    adp_dp_state_t q;
    adp_dp_state_t nxt;

    function automatic adp_region_t region_of(input logic [11:0] addr);
        if (addr[11:10] == 2'h0) begin
            return RG_RAM;
        end else if (addr == ADDR_CTRL) begin
            return RG_CTRL;
        end else if (addr == ADDR_STATUS) begin
            return RG_STATUS;
        end
        return RG_NONE;
    endfunction

    function automatic logic is_reserved(input logic [7:0] idx);
        return (idx >= IDX_RESERVED_FIRST) && (idx <= IDX_RESERVED_LAST);
    endfunction

    // The four accumulators share one read path; RAM is the fourth.
    function automatic logic [23:0] acc_read(
        input logic [2:0][23:0] acc,
        input logic [23:0] ram_word,
        input adp_acc_sel_t sel
    );
        if (sel == ACC_RAM) begin
            return ram_word; // RL2 RL8
        end
        return acc[sel[1:0]];
    endfunction

    function automatic logic [23:0] quarter_sum(
        input logic [23:0] w0,
        input logic [23:0] w1,
        input logic [23:0] w2,
        input logic [23:0] w3
    );
        logic [25:0] s;
        s = {{2{w0[23]}}, w0} + {{2{w1[23]}}, w1}
            + {{2{w2[23]}}, w2} + {{2{w3[23]}}, w3};
        return s[25:2];
    endfunction

    // ************************************************************
    // Operand selection and helpers
    // ************************************************************
    logic op_fire;
    logic [23:0] ram_sel;
    logic [23:0] dst_v;
    logic [23:0] src_v;
    logic [23:0] alu_result;
    logic alu_carry;
    logic alu_ovf;
    logic alu_calc;
    logic alu_writes;
    logic ee_we;
    logic [7:0] ee_rdata;
    logic [1:0] wr_en;
    adp_acc_sel_t wr_sel [2];
    logic [23:0] wr_val [2];
    logic [23:0] bridge_q;
    logic bus_wr;
    logic [7:0] bus_idx;
    logic [7:0] rd_idx;

    assign op_fire = seq_op.valid && q.seq_ready;
    assign ram_sel = q.ram[q.ptr]; // RL6
    assign dst_v = acc_read(q.acc, ram_sel, seq_op.dst);
    assign src_v = acc_read(q.acc, ram_sel, seq_op.src);
    assign bridge_q = quarter_sum(q.ram[IDX_BRIDGE1], q.ram[IDX_BRIDGE2],
        q.ram[IDX_BRIDGE3], q.ram[IDX_BRIDGE4]);
    assign bus_wr = q.aw_held && q.w_held && !q.bvalid;
    assign bus_idx = q.awaddr[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign ee_we = op_fire && (seq_op.code == OP_EEPROM_WRITE);

    adp_alu u_alu (
        .code(seq_op.code),
        .a(dst_v),
        .b(src_v),
        .result(alu_result),
        .carry(alu_carry),
        .ovf(alu_ovf),
        .calc(alu_calc),
        .writes(alu_writes)
    );

    adp_eeprom u_eeprom (
        .aclk(aclk),
        .we(ee_we),
        .addr(q.ptr[6:0]), // RL5
        .wdata(src_v[7:0]),
        .rdata(ee_rdata)
    );

    // Accumulator write ports; port 0 also feeds the flags.
    always_comb begin
        wr_en = 2'h0;
        wr_sel[0] = seq_op.dst;
        wr_sel[1] = seq_op.src;
        wr_val[0] = alu_result;
        wr_val[1] = dst_v;
        if (op_fire) begin
            unique case (seq_op.code)
                OP_SWAP: begin
                    wr_en = 2'h3;
                    wr_val[0] = src_v;
                end
                OP_EEPROM_READ: begin
                    wr_en = 2'h1;
                    wr_val[0] = {16'h0000, ee_rdata}; // RL5
                end
                default: begin
                    wr_en = {1'b0, alu_writes};
                end
            endcase
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt = q;
        nxt.jump_taken = 1'b0;
        nxt.gpio_s1 = gpio_pins;
        nxt.gpio_s2 = q.gpio_s1;
        nxt.gpio_last = q.gpio_s2;
        nxt.key_s1 = key_inputs;
        nxt.key_s2 = q.key_s1;
        nxt.key_last = q.key_s2;

        // Address and data are taken in either order and held until used.
        if (s_axi_awvalid && q.awready) begin
            nxt.aw_held = 1'b1;
            nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            nxt.w_held = 1'b1;
            nxt.wdata = s_axi_wdata;
            nxt.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            nxt.bvalid = 1'b0;
        end
        if (bus_wr) begin
            nxt.aw_held = 1'b0;
            nxt.w_held = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = RESP_OKAY;
            unique case (region_of(q.awaddr))
                RG_RAM: begin
                    if (!is_reserved(bus_idx)) begin // RL16
                        for (int i = 0; i < 3; i++) begin
                            if (q.wstrb[i]) begin
                                nxt.ram[bus_idx][8*i +: 8] =
                                    q.wdata[8*i +: 8];
                            end
                        end
                    end
                end
                RG_CTRL: begin
                    if (q.wstrb[0]) begin
                        nxt.halt = q.wdata[CTRL_HALT_BIT];
                    end
                end
                RG_STATUS: begin
                end
                RG_NONE: begin
                    nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        nxt.awready = !nxt.aw_held && !nxt.bvalid;
        nxt.wready = !nxt.w_held && !nxt.bvalid;

        if (q.rvalid && s_axi_rready) begin
            nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            nxt.rvalid = 1'b1;
            nxt.rresp = RESP_OKAY;
            nxt.rdata = '0;
            unique case (region_of(s_axi_araddr))
                RG_RAM: begin
                    if (!is_reserved(rd_idx)) begin // RL16
                        nxt.rdata = {8'h00, q.ram[rd_idx]};
                    end
                end
                RG_CTRL: begin
                    nxt.rdata[CTRL_HALT_BIT] = q.halt;
                end
                RG_STATUS: begin
                    nxt.rdata[STATUS_PTR_LSB +: 8] = q.ptr;
                    nxt.rdata[STATUS_FLAGS_LSB +: 4] = q.flags;
                end
                RG_NONE: begin
                    nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        nxt.arready = !nxt.rvalid;
        nxt.seq_ready = !nxt.halt;

        // Edge bits are sticky and a new edge beats a bus write.
        nxt.ram[IDX_KEY_FALL] = nxt.ram[IDX_KEY_FALL]
            | (q.key_last & ~q.key_s2); // RL19
        nxt.ram[IDX_KEY_RISE] = nxt.ram[IDX_KEY_RISE]
            | (~q.key_last & q.key_s2); // RL19
        nxt.ram[IDX_KEY_PRESSED] = q.key_s2; // RL19
        nxt.ram[IDX_GPIO_STATUS][GPIO_FALL_LSB +: 8] =
            nxt.ram[IDX_GPIO_STATUS][GPIO_FALL_LSB +: 8]
            | (q.gpio_last & ~q.gpio_s2); // RL18
        nxt.ram[IDX_GPIO_STATUS][GPIO_RISE_LSB +: 8] =
            nxt.ram[IDX_GPIO_STATUS][GPIO_RISE_LSB +: 8]
            | (~q.gpio_last & q.gpio_s2); // RL18
        nxt.ram[IDX_GPIO_STATUS][GPIO_LEVEL_LSB +: 8] = q.gpio_s2; // RL18
        nxt.ram[IDX_BRIDGE_SUM] = bridge_q; // RL17

        // The sequencer has the last word: its writes win over the bus.
        if (op_fire) begin
            unique case (seq_op.code)
                OP_SET_PTR: nxt.ptr = seq_op.imm; // RL3 RL4
                OP_INC_PTR: nxt.ptr = q.ptr + 8'h01; // RL3 RL4
                OP_JUMP_TEST: begin
                    nxt.jump_taken = q.flags[seq_op.imm[1:0]]; // RL9
                end
                default: begin
                end
            endcase
        end
        for (int p = 0; p < 2; p++) begin
            if (wr_en[p]) begin
                if (wr_sel[p] == ACC_RAM) begin
                    nxt.ram[q.ptr] = wr_val[p]; // RL2 RL8
                end else begin
                    nxt.acc[wr_sel[p][1:0]] = wr_val[p]; // RL7 RL8
                end
            end
        end
        if (wr_en[0]) begin // RL20
            nxt.flags.ne = (wr_val[0] == 24'h000000); // RL10 RL13
            nxt.flags.sign = wr_val[0][23]; // RL10 RL14
            if (alu_calc && seq_op.code != OP_SWAP) begin
                nxt.flags.carry = alu_carry; // RL11 RL12
                nxt.flags.ovf = alu_ovf; // RL11 RL15
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= nxt;
        end
    end

    assign seq_ready = q.seq_ready;
    assign cond_flags = q.flags;
    assign jump_taken = q.jump_taken;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic no_ptr_op;
    assign no_ptr_op = !(op_fire && (seq_op.code == OP_SET_PTR
        || seq_op.code == OP_INC_PTR));

    ptr_hold_a: assert property (no_ptr_op |=> $stable(q.ptr)) // RL4
        else $error("Pointer moved without a pointer opcode.");
    ptr_step_a: assert property ( // RL4
        op_fire && seq_op.code == OP_INC_PTR |=> q.ptr == $past(q.ptr) + 8'h01)
        else $error("Pointer increment did not step by one.");
    ram_keep_a: assert property ( // RL3
        op_fire && seq_op.code == OP_SET_PTR && seq_op.imm < IDX_BRIDGE1
        && !bus_wr |=> q.ram[q.ptr] == $past(q.ram[seq_op.imm]))
        else $error("Setting the pointer changed the selected word.");
    ne_flag_a: assert property ( // RL13
        wr_en[0] && wr_val[0] != 24'h000000 |=> !q.flags.ne)
        else $error("Not-equal flag not cleared on non-zero write.");
    sign_flag_a: assert property ( // RL14
        wr_en[0] |=> q.flags.sign == $past(wr_val[0][23]))
        else $error("Sign flag does not follow result top bit.");
    flags_hold_a: assert property (wr_en == 2'h0 |=> $stable(q.flags)) // RL20
        else $error("Flags changed without an accumulator write.");
    add_carry_a: assert property ( // RL12
        op_fire && seq_op.code == OP_ADD
        |=> q.flags.carry == $past(({1'b0, dst_v} + {1'b0, src_v}) >> 24))
        else $error("Add carry flag wrong.");
    bridge_sum_a: assert property ( // RL17
        !(wr_en != 2'h0 && q.ptr == IDX_BRIDGE_SUM)
        |=> q.ram[IDX_BRIDGE_SUM] == $past(bridge_q))
        else $error("Compensated bridge word not a quarter of the sum.");
    reserved_a: assert property ( // RL16
        bus_wr && is_reserved(bus_idx) && !(wr_en != 2'h0 && q.ptr == bus_idx)
        |=> q.ram[$past(bus_idx)] == $past(q.ram[bus_idx]))
        else $error("Bus write reached a reserved word.");
    key_pressed_a: assert property ( // RL19
        !(wr_en != 2'h0 && q.ptr == IDX_KEY_PRESSED)
        |=> q.ram[IDX_KEY_PRESSED] == $past(q.key_s2))
        else $error("Key pressed word does not follow keys.");

    swap_c: cover property (op_fire && seq_op.code == OP_SWAP);
    ee_read_c: cover property (op_fire && seq_op.code == OP_EEPROM_READ);
    jump_c: cover property (q.jump_taken);
    bus_rw_c: cover property (bus_wr ##[1:20] q.rvalid);
endmodule
`default_nettype wire

/* hw/adp_pkg.sv */
// Constants, types and register map of the accumulator and RAM datapath.
// What this block does
// [RL1] Data RAM has its own bus: 256 words of 24 bits each.
// [RL2] The RAM word selected by the pointer acts as a fourth accumulator.
// [RL3] Loading or changing the pointer never alters any RAM word.
// [RL4] Only the set and increment pointer opcodes change the pointer.
// [RL5] The pointer also selects one of 128 EEPROM bytes for byte opcodes.
// [RL6] All other opcodes treat the pointer as a RAM address.
// [RL7] Three independent 24-bit accumulators X, Y and Z exist.
// [RL8] Moves, swaps and arithmetic may use any of the four accumulators.
// [RL9] Four condition flags exist; a jump can test each one.
// [RL10] Not-equal and sign flags update on every accumulator write.
// [RL11] Carry and overflow update on add, subtract and shift calculations.
// [RL12] Carry holds the add/subtract carry or the bit shifted out.
// [RL13] Not-equal flag goes to zero when a non-zero result is written.
// [RL14] Sign flag is set when the written result has its top bit set.
// [RL15] Overflow flags signed two's complement overflow of add or subtract.
// [RL16] RAM words 64 to 79 are reserved for internal use.
// [RL17] Compensated bridge word is a quarter of the four bridge ratios.
// [RL18] One word shows falling, rising and current state of 8 GPIO pins.
// [RL19] One word shows 24 key states; two more record their edges.
// [RL20] Operations writing no accumulator leave all four flags unchanged.
package adp_pkg;
    localparam int WORD_W = 24;
    localparam int RAM_WORDS = 256;
    localparam int EE_BYTES = 128;
    // Word indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_BRIDGE1 = 8'h10;
    localparam logic [7:0] IDX_BRIDGE2 = 8'h11;
    localparam logic [7:0] IDX_BRIDGE3 = 8'h12;
    localparam logic [7:0] IDX_BRIDGE4 = 8'h13;
    localparam logic [7:0] IDX_BRIDGE_SUM = 8'h14;
    localparam logic [7:0] IDX_TEMPERATURE = 8'h15;
    localparam logic [7:0] IDX_MEAS_STATUS = 8'h16;
    localparam logic [7:0] IDX_PORT_A1_TIME = 8'h17;
    localparam logic [7:0] IDX_TDC_RES = 8'h18;
    localparam logic [7:0] IDX_SUPPLY_VOLTAGE = 8'h19;
    localparam logic [7:0] IDX_KEY_FALL = 8'h1A;
    localparam logic [7:0] IDX_KEY_RISE = 8'h1B;
    localparam logic [7:0] IDX_KEY_PRESSED = 8'h1C;
    localparam logic [7:0] IDX_GPIO_STATUS = 8'h1D;
    localparam logic [7:0] IDX_TIMER_SNAP = 8'h1E;
    localparam logic [7:0] IDX_SPAN_RATIO = 8'h1F;
    localparam logic [7:0] IDX_CONFIG_FIRST = 8'h30;
    localparam logic [7:0] IDX_CONFIG_LAST = 8'h3F;
    localparam logic [7:0] IDX_RESERVED_FIRST = 8'h40;
    localparam logic [7:0] IDX_RESERVED_LAST = 8'h4F;
    localparam logic [7:0] IDX_SERIAL_CFG = 8'h50;
    // GPIO status word field positions.
    localparam int GPIO_LEVEL_LSB = 0;
    localparam int GPIO_RISE_LSB = 8;
    localparam int GPIO_FALL_LSB = 16;
    // Own control and status registers above the RAM window.
    localparam logic [11:0] ADDR_CTRL = 12'h400;
    localparam logic [11:0] ADDR_STATUS = 12'h404;
    localparam int CTRL_HALT_BIT = 0;
    localparam int STATUS_PTR_LSB = 0;
    localparam int STATUS_FLAGS_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_SET_PTR = 4'h1, OP_INC_PTR = 4'h2,
        OP_MOVE = 4'h3, OP_SWAP = 4'h4, OP_ADD = 4'h5, OP_SUB = 4'h6,
        OP_SHIFT_RIGHT = 4'h7, OP_SHIFT_LEFT = 4'h8, OP_ROTATE_RIGHT = 4'h9,
        OP_MULTIPLY_24BIT = 4'hA, OP_CLEAR = 4'hB, OP_EEPROM_READ = 4'hC,
        OP_EEPROM_WRITE = 4'hD, OP_JUMP_TEST = 4'hE
    } adp_op_code_t;

    typedef enum logic [1:0] {
        ACC_X = 2'h0, ACC_Y = 2'h1, ACC_Z = 2'h2, ACC_RAM = 2'h3
    } adp_acc_sel_t;

    typedef enum logic [1:0] {
        RG_RAM = 2'h0, RG_CTRL = 2'h1, RG_STATUS = 2'h2, RG_NONE = 2'h3
    } adp_region_t;

    typedef struct packed {
        logic ovf;
        logic sign;
        logic ne;
        logic carry;
    } adp_flags_t;

    typedef struct packed {
        logic valid;
        adp_op_code_t code;
        adp_acc_sel_t dst;
        adp_acc_sel_t src;
        logic [7:0] imm;
    } adp_op_t;
endpackage

/* hw/adp_alu.sv */
// Combinational result and carry/overflow logic of the accumulator ALU.
`timescale 1ns/1ps
`default_nettype none
module adp_alu (
    input wire adp_pkg::adp_op_code_t code,
    input wire logic [23:0] a,
    input wire logic [23:0] b,
    output logic [23:0] result,
    output logic carry,
    output logic ovf,
    output logic calc,
    output logic writes
);
    import adp_pkg::*;
    logic [24:0] sum;
    logic [24:0] diff;
    logic [47:0] prod;

    always_comb begin
        sum = {1'b0, a} + {1'b0, b};
        diff = {1'b0, a} - {1'b0, b};
        prod = a * b;
        result = a;
        carry = 1'b0;
        ovf = 1'b0;
        calc = 1'b0;
        writes = 1'b0;
        unique case (code)
            OP_MOVE: begin
                result = b;
                writes = 1'b1;
            end
            OP_ADD: begin
                result = sum[23:0];
                carry = sum[24]; // RL12
                ovf = (a[23] == b[23]) && (sum[23] != a[23]); // RL15
                calc = 1'b1; // RL11
                writes = 1'b1;
            end
            OP_SUB: begin
                result = diff[23:0];
                carry = diff[24]; // RL12
                ovf = (a[23] != b[23]) && (diff[23] != a[23]); // RL15
                calc = 1'b1; // RL11
                writes = 1'b1;
            end
            OP_SHIFT_RIGHT: begin
                result = {1'b0, a[23:1]};
                carry = a[0]; // RL12
                calc = 1'b1;
                writes = 1'b1;
            end
            OP_SHIFT_LEFT: begin
                result = {a[22:0], 1'b0};
                carry = a[23]; // RL12
                calc = 1'b1;
                writes = 1'b1;
            end
            OP_ROTATE_RIGHT: begin
                result = {a[0], a[23:1]};
                carry = a[0]; // RL12
                calc = 1'b1;
                writes = 1'b1;
            end
            OP_MULTIPLY_24BIT: begin
                result = prod[23:0];
                writes = 1'b1;
            end
            OP_CLEAR: begin
                result = '0;
                writes = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule
`default_nettype wire

/* hw/adp_eeprom.sv */
// Byte-wide user EEPROM store addressed by the RAM address pointer.
`timescale 1ns/1ps
`default_nettype none
module adp_eeprom (
    input wire logic aclk,
    input wire logic we,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    import adp_pkg::*;
    typedef struct packed {
        logic [EE_BYTES-1:0][7:0] mem;
    } adp_ee_state_t;
    adp_ee_state_t q;
    adp_ee_state_t nxt;

    // Contents are nonvolatile calibration data, so reset leaves them alone.
    always_comb begin
        nxt = q;
        if (we) begin
            nxt.mem[addr] = wdata; // RL5
        end
    end

    always_ff @(posedge aclk) begin
        q <= nxt;
    end

    assign rdata = q.mem[addr]; // RL5
endmodule
`default_nettype wire

/* tb/adp_seq_model.sv */
// Behavioural instruction sequencer that feeds opcodes to the datapath.
`timescale 1ns/1ps
`default_nettype none
module adp_seq_model (
    input wire logic aclk,
    input wire logic seq_ready,
    output var adp_pkg::adp_op_t seq_op
);
    import adp_pkg::*;
    initial begin
        seq_op = '0;
    end
    // The op and its fields stay put until an edge that sees seq_ready.
    task automatic issue(input adp_op_code_t c, input adp_acc_sel_t d,
                         input adp_acc_sel_t s, input logic [7:0] i);
        @(posedge aclk);
        seq_op <= '{valid: 1'b1, code: c, dst: d, src: s, imm: i};
        do @(posedge aclk); while (!seq_ready);
        seq_op <= '0;
    endtask
endmodule
`default_nettype wire

/* tb/adp_datapath_tb.sv */
// Self-checking bench for the accumulator, pointer RAM and flag datapath.
`timescale 1ns/1ps
`default_nettype none
module adp_datapath_tb;
    import adp_pkg::*;
    logic aclk, aresetn, seq_ready, jump_taken;
    adp_op_t seq_op;
    adp_flags_t cond_flags;
    logic [7:0] gpio_pins;
    logic [23:0] key_inputs;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_fail, total_checks, k;
    adp_datapath u_adp_datapath (.aclk, .aresetn, .seq_op, .seq_ready,
        .cond_flags, .jump_taken, .gpio_pins, .key_inputs, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    adp_seq_model u_adp_seq_model (.aclk, .seq_ready, .seq_op);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    // Flags are looked at once the taking edge's updates have landed.
    task automatic op(input adp_op_code_t c, input adp_acc_sel_t d,
                      input adp_acc_sel_t s, input logic [7:0] i,
                      input logic [3:0] ef);
        u_adp_seq_model.issue(c, d, s, i);
        #1;
        chk(32'(cond_flags), 32'(ef));
    endtask
    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (6000) @(posedge aclk);
        n_fail++;
        give_verdict();
    end
    initial begin
        aresetn = 1'b0;
        gpio_pins = 8'h00;
        key_inputs = 24'h000000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axr(12'h404, 32'h0, RESP_OKAY);
        axw(12'h400, 32'h1, RESP_OKAY);
        axr(12'h400, 32'h1, RESP_OKAY);
        chk(32'(seq_ready), 32'h0);
        axw(12'h400, 32'h0, RESP_OKAY);
        op(OP_SET_PTR, ACC_X, ACC_X, 8'h03, 4'h0);
        op(OP_CLEAR, ACC_RAM, ACC_RAM, 8'h00, 4'h2);
        axw(12'h00C, 32'h7FFFFF, RESP_OKAY);
        op(OP_MOVE, ACC_X, ACC_RAM, 8'h00, 4'h0);
        op(OP_ADD, ACC_RAM, ACC_X, 8'h00, 4'hC);
        axr(12'h00C, 32'hFFFFFE, RESP_OKAY);
        op(OP_ADD, ACC_RAM, ACC_X, 8'h00, 4'h1);
        op(OP_SHIFT_RIGHT, ACC_RAM, ACC_RAM, 8'h00, 4'h1);
        op(OP_INC_PTR, ACC_X, ACC_X, 8'h00, 4'h1);
        axr(12'h404, 32'h104, RESP_OKAY);
        axr(12'h00C, 32'h3FFFFE, RESP_OKAY);
        op(OP_EEPROM_WRITE, ACC_X, ACC_X, 8'h00, 4'h1);
        op(OP_EEPROM_READ, ACC_Y, ACC_X, 8'h00, 4'h1);
        op(OP_MOVE, ACC_RAM, ACC_Y, 8'h00, 4'h1);
        axr(12'h010, 32'h0000FF, RESP_OKAY);
        op(OP_SUB, ACC_RAM, ACC_X, 8'h00, 4'h5);
        axr(12'h010, 32'h800100, RESP_OKAY);
        for (k = 0; k < 4; k++) begin
            op(OP_JUMP_TEST, ACC_X, ACC_X, 8'(k), 4'h5);
            chk(32'(jump_taken), 32'(k % 2 == 0));
            @(posedge aclk);
            #1;
            chk(32'(jump_taken), 32'h0);
        end
        axw(12'h100, 32'h123, RESP_OKAY);
        axr(12'h100, 32'h0, RESP_OKAY);
        op(OP_SET_PTR, ACC_X, ACC_X, 8'h40, 4'h5);
        op(OP_MOVE, ACC_X, ACC_RAM, 8'h00, 4'h3);
        axr(12'h800, 32'h0, RESP_SLVERR);
        axw(12'h800, 32'h1, RESP_SLVERR);
        for (k = 0; k < 4; k++) begin
            axw(12'(32'h40 + 4 * k), 32'(4 * k + 4), RESP_OKAY);
        end
        axr(12'h050, 32'h00000A, RESP_OKAY);
        @(posedge aclk);
        key_inputs <= 24'h000005;
        gpio_pins <= 8'hA5;
        repeat (5) @(posedge aclk);
        axr(12'h070, 32'h000005, RESP_OKAY);
        axr(12'h06C, 32'h000005, RESP_OKAY);
        axr(12'h074, 32'h00A5A5, RESP_OKAY);
        key_inputs <= 24'h000000;
        gpio_pins <= 8'h00;
        repeat (5) @(posedge aclk);
        axr(12'h068, 32'h000005, RESP_OKAY);
        axr(12'h074, 32'hA5A500, RESP_OKAY);
        give_verdict();
    end
endmodule
`default_nettype wire
